/* srp_defs.svh */
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// ==========================================================
// Clock limits and period
`define SRP_CLK_MIN_MHZ      10
`define SRP_CLK_MAX_MHZ      100
`define SRP_CLK_PERIOD_NS    10

// ==========================================================
// Stream widths
`define SRP_VOLT_MASK_W      16
`define SRP_TEMP_MASK_W      9
`define SRP_CHAN_W           4
`define SRP_DATA_W           32

// ==========================================================
// Voltage mask fields
`define SRP_VOLT_EXT_LO      0
`define SRP_VOLT_EXT_HI      1
`define SRP_VOLT_INT_LO      2
`define SRP_VOLT_INT_HI      15
`define SRP_VOLT_FRAC_BITS   16

// ==========================================================
// Temperature mask fields
`define SRP_TEMP_FABRIC_BIT  0
`define SRP_TEMP_TILE_LO     1
`define SRP_TEMP_TILE_HI     6
`define SRP_TEMP_STACK_LO    7
`define SRP_TEMP_STACK_HI    8
`define SRP_TEMP_FRAC_BITS   8
`define SRP_TEMP_INVALID     32'h8000_0000

// ==========================================================
// Command strobe hold, in clock cycles
`define SRP_CMD_HOLD_MIN     1
`define SRP_CMD_HOLD_MAX     3

`endif

/* srp_pkg.sv */
`include "srp_defs.svh"

package srp_pkg;

    // ======================================================
    // Readout end sequencer
    typedef enum logic [2:0] {
        SRP_DEV_IDLE  = 3'b001,
        SRP_DEV_FETCH = 3'b010,
        SRP_DEV_SEND  = 3'b100
    } srp_dev_state_t;

    // ======================================================
    // Requester end sequencer
    typedef enum logic [2:0] {
        SRP_REQ_IDLE = 3'b001,
        SRP_REQ_ASK  = 3'b010,
        SRP_REQ_WAIT = 3'b100
    } srp_req_state_t;

    typedef logic [`SRP_CHAN_W-1:0] srp_chan_t;
    typedef logic [`SRP_DATA_W-1:0] srp_word_t;

endpackage : srp_pkg

/* srp_stream_if.sv */
`timescale 1ns/10ps
`include "srp_defs.svh"

interface srp_stream_if #(
    parameter int MASK_W = `SRP_VOLT_MASK_W
) (
    input logic clk
);
    logic                   cmd_valid;
    logic                   cmd_ready;
    logic [MASK_W-1:0]      cmd_data;
    logic                   rsp_valid;
    logic                   rsp_ready;
    logic [`SRP_CHAN_W-1:0] rsp_channel;
    logic [`SRP_DATA_W-1:0] rsp_data;
    logic                   rsp_startofpacket;
    logic                   rsp_endofpacket;

    modport dev (
        input  cmd_valid, cmd_data, rsp_ready,
        output cmd_ready, rsp_valid, rsp_channel, rsp_data,
        output rsp_startofpacket, rsp_endofpacket
    );

    modport req (
        output cmd_valid, cmd_data, rsp_ready,
        input  cmd_ready, rsp_valid, rsp_channel, rsp_data,
        input  rsp_startofpacket, rsp_endofpacket
    );
endinterface : srp_stream_if

/* srp_readout.sv */
`timescale 1ns/10ps
`include "srp_defs.svh"

// What this block does
// - Clock runs between 10 and 100 MHz.
// - Active-low reset, applied asynchronously, clears state.
// - Both streams transfer when valid and ready.
// - Requester presents mask with request strobe.
// - Accept high only when a command fits.
// - Voltage mask 16 bits, 2 external inputs.
// - Requester sets only existing channel bits.
// - Temperature mask 9 bits: fabric, tiles, stacks.
// - Reading strobe marks exactly the valid beats.
// - Each reading carries a 4-bit channel index.
// - Voltage word 32 bits, 16 fraction bits.
// - Temperature word signed, 8 fraction bits.
// - Invalid temperature returns most-negative code.
// - First-beat flag on first reading.
// - Last-beat flag on final reading.
// - Request strobe held one to three cycles.
// - One beat per set mask bit.
// - Accept stays low while awaiting response.
// - Requester idles strobe and mask before operation.
// - Receiver ignores data while strobe low.

module srp_readout
    import srp_pkg::*;
#(
    parameter bit TEMP_VARIANT = 1'b0,
    parameter int MASK_W       = TEMP_VARIANT ? `SRP_TEMP_MASK_W : `SRP_VOLT_MASK_W
) (
    input  logic                   clk,          // Stream clock, 10..100 MHz
    input  logic                   rst_n,        // Async reset, active low
    srp_stream_if.dev              link,         // Command and response streams
    output logic                   mgmt_req,     // Reading request to processor
    output logic [`SRP_CHAN_W-1:0] mgmt_chan,    // Channel being requested
    input  logic                   mgmt_ack,     // Processor returns a reading
    input  logic [`SRP_DATA_W-1:0] mgmt_value,   // Reading from processor
    input  logic                   mgmt_invalid, // Processor flags reading bad
    output logic                   busy          // Command in progress
);

    // ======================================================
    // Mask helpers

    // Index of the lowest set bit; ascending order falls out of this
    function automatic srp_chan_t lowest_idx(input logic [MASK_W-1:0] m);
        srp_chan_t idx;
        idx = '0;
        for (int i = MASK_W - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = srp_chan_t'(i);
            end
        end
        return idx;
    endfunction : lowest_idx

    function automatic logic [MASK_W-1:0] drop_lowest(input logic [MASK_W-1:0] m);
        return m & (m - {{(MASK_W-1){1'b0}}, 1'b1});
    endfunction : drop_lowest

    // ======================================================
    // State

    srp_dev_state_t      state_ff,  nxt_state;
    logic [MASK_W-1:0]   pend_ff,   nxt_pend;
    srp_chan_t           chan_ff,   nxt_chan;
    srp_word_t           data_ff,   nxt_data;
    logic                valid_ff,  nxt_valid;
    logic                sop_ff,    nxt_sop;
    logic                eop_ff,    nxt_eop;
    logic                first_ff,  nxt_first;
    logic                req_ff,    nxt_req;

    logic                cmd_take;
    logic                beat_take;

    // low from accept of a non-empty mask until packet end
    assign link.cmd_ready = (state_ff == SRP_DEV_IDLE);

    assign cmd_take  = link.cmd_valid && link.cmd_ready;
    assign beat_take = valid_ff && link.rsp_ready;

    // ======================================================
    // Sequencer next values

    always_comb begin
        nxt_state = state_ff;
        nxt_pend  = pend_ff;
        nxt_chan  = chan_ff;
        nxt_data  = data_ff;
        nxt_valid = valid_ff;
        nxt_sop   = sop_ff;
        nxt_eop   = eop_ff;
        nxt_first = first_ff;
        nxt_req   = req_ff;
        case (state_ff)
            SRP_DEV_IDLE: begin
                if (cmd_take) begin
                    // Empty mask: accepted, no packet follows
                    if (link.cmd_data != '0) begin
                        nxt_chan  = lowest_idx(link.cmd_data);
                        nxt_pend  = drop_lowest(link.cmd_data);
                        nxt_first = 1'b1;
                        nxt_req   = 1'b1;
                        nxt_state = SRP_DEV_FETCH;
                    end
                end
            end
            SRP_DEV_FETCH: begin
                if (mgmt_ack) begin
                    nxt_req = 1'b0;
                    if (TEMP_VARIANT && mgmt_invalid) begin
                        nxt_data = `SRP_TEMP_INVALID;
                    end else begin
                        // temperature word passed as signed 24.8
                        nxt_data = mgmt_value;
                    end
                    nxt_valid = 1'b1;
                    nxt_sop   = first_ff;
                    nxt_eop   = (pend_ff == '0);
                    nxt_state = SRP_DEV_SEND;
                end
            end
            SRP_DEV_SEND: begin
                if (beat_take) begin
                    // strobe falls once the beat is taken
                    nxt_valid = 1'b0;
                    nxt_sop   = 1'b0;
                    nxt_eop   = 1'b0;
                    nxt_first = 1'b0;
                    if (pend_ff == '0) begin
                        nxt_state = SRP_DEV_IDLE;
                    end else begin
                        nxt_chan  = lowest_idx(pend_ff);
                        nxt_pend  = drop_lowest(pend_ff);
                        nxt_req   = 1'b1;
                        nxt_state = SRP_DEV_FETCH;
                    end
                end
            end
            default: begin
                nxt_state = SRP_DEV_IDLE;
                nxt_valid = 1'b0;
                nxt_req   = 1'b0;
                nxt_pend  = '0;
            end
        endcase
    end

    // ======================================================
    // Sequencer registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SRP_DEV_IDLE;
            pend_ff  <= '0;
            chan_ff  <= '0;
            data_ff  <= '0;
            valid_ff <= 1'b0;
            sop_ff   <= 1'b0;
            eop_ff   <= 1'b0;
            first_ff <= 1'b0;
            req_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pend_ff  <= nxt_pend;
            chan_ff  <= nxt_chan;
            data_ff  <= nxt_data;
            valid_ff <= nxt_valid;
            sop_ff   <= nxt_sop;
            eop_ff   <= nxt_eop;
            first_ff <= nxt_first;
            req_ff   <= nxt_req;
        end
    end

    // ======================================================
    // Outputs

    // Processor request stays up until its acknowledge
    assign mgmt_req  = req_ff;
    assign mgmt_chan = chan_ff;
    assign busy      = (state_ff != SRP_DEV_IDLE);

    // data only meaningful with the strobe
    assign link.rsp_valid         = valid_ff;
    assign link.rsp_channel       = chan_ff;
    assign link.rsp_data          = data_ff;
    assign link.rsp_startofpacket = sop_ff;
    assign link.rsp_endofpacket   = eop_ff;

endmodule : srp_readout

/* srp_requester.sv */
`timescale 1ns/10ps
`include "srp_defs.svh"

module srp_requester
    import srp_pkg::*;
#(
    parameter int MASK_W   = `SRP_VOLT_MASK_W,
    parameter int HOLD_MAX = `SRP_CMD_HOLD_MAX
) (
    input  logic                   clk,       // Stream clock
    input  logic                   rst_n,     // Async reset, active low
    srp_stream_if.req              link,      // Command and response streams
    input  logic                   user_mode, // Device has left configuration
    input  logic                   usr_start, // Pulse: sample the mask
    input  logic [MASK_W-1:0]      usr_mask,  // Channels wanted
    input  logic                   usr_stall, // Hold off response beats
    output logic                   usr_busy,  // Request or packet outstanding
    output logic                   usr_miss,  // Pulse: command not accepted
    output logic                   rd_valid,  // Pulse: reading captured
    output logic [`SRP_CHAN_W-1:0] rd_chan,   // Captured channel
    output logic [`SRP_DATA_W-1:0] rd_value,  // Captured reading
    output logic                   rd_first,  // Captured first flag
    output logic                   rd_last    // Captured last flag
);

    // ======================================================
    // State

    srp_req_state_t     state_ff,  nxt_state;
    logic               cval_ff,   nxt_cval;
    logic [MASK_W-1:0]  cdata_ff,  nxt_cdata;
    logic [1:0]         hold_ff,   nxt_hold;
    logic               miss_ff,   nxt_miss;
    logic               beat;

    // beat taken when both are high
    assign link.rsp_ready = !usr_stall;
    assign beat           = link.rsp_valid && link.rsp_ready;

    always_comb begin
        nxt_state = state_ff;
        nxt_cval  = cval_ff;
        nxt_cdata = cdata_ff;
        nxt_hold  = hold_ff;
        nxt_miss  = 1'b0;
        case (state_ff)
            SRP_REQ_IDLE: begin
                // empty mask would yield no packet, so refused
                if (usr_start && user_mode && (usr_mask != '0)) begin
                    nxt_cval  = 1'b1;
                    nxt_cdata = usr_mask;
                    nxt_hold  = 2'h0;
                    nxt_state = SRP_REQ_ASK;
                end
            end
            SRP_REQ_ASK: begin
                if (link.cmd_ready) begin
                    nxt_cval  = 1'b0;
                    nxt_cdata = '0;
                    nxt_state = SRP_REQ_WAIT;
                // give up after the longest hold
                end else if (hold_ff == 2'(HOLD_MAX - 1)) begin
                    nxt_cval  = 1'b0;
                    nxt_cdata = '0;
                    nxt_miss  = 1'b1;
                    nxt_state = SRP_REQ_IDLE;
                end else begin
                    nxt_hold = hold_ff + 2'h1;
                end
            end
            SRP_REQ_WAIT: begin
                // flags read only with the strobe
                if (beat && link.rsp_endofpacket) begin
                    nxt_state = SRP_REQ_IDLE;
                end
            end
            default: begin
                nxt_state = SRP_REQ_IDLE;
                nxt_cval  = 1'b0;
                nxt_cdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SRP_REQ_IDLE;
            cval_ff  <= 1'b0;
            cdata_ff <= '0;
            hold_ff  <= 2'h0;
            miss_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cval_ff  <= nxt_cval;
            cdata_ff <= nxt_cdata;
            hold_ff  <= nxt_hold;
            miss_ff  <= nxt_miss;
        end
    end

    // ======================================================
    // Capture of response beats

    // captured only on a real beat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_chan  <= '0;
            rd_value <= '0;
            rd_first <= 1'b0;
            rd_last  <= 1'b0;
        end else begin
            rd_valid <= beat;
            if (beat) begin
                rd_chan  <= link.rsp_channel;
                rd_value <= link.rsp_data;
                rd_first <= link.rsp_startofpacket;
                rd_last  <= link.rsp_endofpacket;
            end
        end
    end

    assign link.cmd_valid = cval_ff;
    assign link.cmd_data  = cdata_ff;
    assign usr_busy       = (state_ff != SRP_REQ_IDLE);
    assign usr_miss       = miss_ff;

endmodule : srp_requester

/* srp_stream_asserts.sv */
`timescale 1ns/10ps

// ============================================================
// Stream checker for the link between both ends
module srp_stream_asserts #(
    parameter int MASK_W = 16
) (
    input logic              clk,               // Stream clock
    input logic              rst_n,             // Reset, active low
    input logic              cmd_valid,         // Command strobe
    input logic              cmd_ready,         // Command accept
    input logic [MASK_W-1:0] cmd_data,          // Channel mask
    input logic              rsp_valid,         // Reading strobe
    input logic              rsp_ready,         // Reading taken
    input logic [3:0]        rsp_channel,       // Channel index
    input logic [31:0]       rsp_data,          // Reading
    input logic              rsp_startofpacket, // First beat flag
    input logic              rsp_endofpacket    // Last beat flag
);
    // Channels still owed; cleared bit by bit so order errors show at once
    logic [MASK_W-1:0] pend_ff, nxt_pend, mask_ff, nxt_mask, ch_bit;

    assign ch_bit = MASK_W'(1) << rsp_channel;

    always_comb begin
        nxt_pend = pend_ff;
        nxt_mask = mask_ff;
        if (cmd_valid && cmd_ready) begin
            nxt_pend = cmd_data;
            nxt_mask = cmd_data;
        end else if (rsp_valid && rsp_ready) begin
            nxt_pend = pend_ff & ~ch_bit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= '0;
            mask_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
            mask_ff <= nxt_mask;
        end
    end

    // ============================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_hold_beat: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_channel))
        else $error("Beat changed while stalled");
    a_take_drops_ready: assert property (
        cmd_valid && cmd_ready |=> !cmd_ready) else $error("Accept stayed high");
    a_busy_no_ready: assert property (
        rsp_valid |-> !cmd_ready) else $error("Accept high during packet");
    a_ready_after_last: assert property (
        rsp_valid && rsp_ready && rsp_endofpacket |=> cmd_ready && !rsp_valid)
        else $error("Accept not back after last beat");
    a_beat_one_shot: assert property (
        rsp_valid && rsp_ready |=> !rsp_valid) else $error("Strobe held after take");
    a_beat_order: assert property (
        rsp_valid |-> (pend_ff & (ch_bit | (ch_bit - 1'b1))) == ch_bit)
        else $error("Beat channel out of order");
    a_first_flag: assert property (
        rsp_valid |-> rsp_startofpacket == (pend_ff == mask_ff)) else $error("Bad first flag");
    a_last_flag: assert property (
        rsp_valid |-> rsp_endofpacket == (pend_ff == ch_bit)) else $error("Bad last flag");
    a_strobe_mask: assert property (
        1'b1 |-> cmd_valid == (|cmd_data)) else $error("Mask not with strobe");
    a_strobe_short: assert property (
        $rose(cmd_valid) |-> ##[1:3] !cmd_valid) else $error("Strobe held too long");

    c_take: cover property (cmd_valid && cmd_ready);
    c_stall: cover property (rsp_valid && !rsp_ready);
    c_single: cover property (rsp_valid && rsp_startofpacket && rsp_endofpacket);
endmodule : srp_stream_asserts

/* sensor_readout_stream_port_tb_top.sv */
`timescale 1ns/10ps
`include "srp_defs.svh"

module sensor_readout_stream_port_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        user_mode = 1'b0;
    logic        usr_start = 1'b0;
    logic [15:0] usr_mask = '0;
    logic        usr_stall = 1'b0;
    logic        usr_busy, rd_valid, rd_first, rd_last, t_busy, v_busy, usr_miss;
    logic        miss_seen = 1'b0;
    logic [3:0]  rd_chan, v_chan, t_chan;
    logic [31:0] rd_value, v_val = '0, t_val = '0;
    logic        v_req, v_ack = 1'b0, v_inv = 1'b0, t_req, t_ack = 1'b0, t_inv = 1'b0;
    logic [7:0]  v_cnt = '0, t_cnt = '0, ack_dly = '0;
    logic [3:0]  bad_ch = 4'h3;
    logic [37:0] bq[$];
    int          mismatches = 0, cmp_count = 0, cyc = 0;

    srp_stream_if #(.MASK_W(16)) v_if (.clk(clk));
    srp_stream_if #(.MASK_W(9))  t_if (.clk(clk));

    srp_requester i_srp_requester (
        .clk(clk), .rst_n(rst_n), .link(v_if), .user_mode(user_mode), .usr_start(usr_start),
        .usr_mask(usr_mask), .usr_stall(usr_stall), .usr_busy(usr_busy), .usr_miss(usr_miss),
        .rd_valid(rd_valid), .rd_chan(rd_chan), .rd_value(rd_value), .rd_first(rd_first),
        .rd_last(rd_last));
    srp_readout #(.TEMP_VARIANT(1'b0)) i_srp_readout (
        .clk(clk), .rst_n(rst_n), .link(v_if), .mgmt_req(v_req), .mgmt_chan(v_chan),
        .mgmt_ack(v_ack), .mgmt_value(v_val), .mgmt_invalid(v_inv), .busy(v_busy));
    // Second readout, temperature variant, driven raw to break requester rules
    srp_readout #(.TEMP_VARIANT(1'b1)) i_srp_readout_tmp (
        .clk(clk), .rst_n(rst_n), .link(t_if), .mgmt_req(t_req), .mgmt_chan(t_chan),
        .mgmt_ack(t_ack), .mgmt_value(t_val), .mgmt_invalid(t_inv), .busy(t_busy));
    srp_stream_asserts #(.MASK_W(16)) i_srp_stream_asserts (
        .clk(clk), .rst_n(rst_n), .cmd_valid(v_if.cmd_valid), .cmd_ready(v_if.cmd_ready),
        .cmd_data(v_if.cmd_data), .rsp_valid(v_if.rsp_valid), .rsp_ready(v_if.rsp_ready),
        .rsp_channel(v_if.rsp_channel), .rsp_data(v_if.rsp_data),
        .rsp_startofpacket(v_if.rsp_startofpacket), .rsp_endofpacket(v_if.rsp_endofpacket));

    // 100 MHz, top of the supported range
    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] val_of(input logic [3:0] ch);
        return {4'h1, ch, 8'h2c, ch, 12'h0a5};
    endfunction : val_of

    // ============================================================
    // Processor stand-ins: one-cycle ack after ack_dly cycles
    always @(posedge clk) begin
        v_cnt <= v_req ? v_cnt + 8'h01 : 8'h00;
        v_ack <= v_req && !v_ack && (v_cnt >= ack_dly);
        v_val <= val_of(v_chan);
        v_inv <= (v_chan == bad_ch);
        t_cnt <= t_req ? t_cnt + 8'h01 : 8'h00;
        t_ack <= t_req && !t_ack && (t_cnt >= ack_dly);
        t_val <= val_of(t_chan);
        t_inv <= (t_chan == bad_ch);
        // Sticky, since a give-up pulse lasts one cycle only
        if (usr_miss === 1'b1) miss_seen <= 1'b1;
        if (rd_valid === 1'b1) bq.push_back({rd_first, rd_last, rd_chan, rd_value});
        if (t_if.rsp_valid === 1'b1 && t_if.rsp_ready === 1'b1)
            bq.push_back({t_if.rsp_startofpacket, t_if.rsp_endofpacket, t_if.rsp_channel,
                          t_if.rsp_data});
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // ============================================================
    // Comparison and report
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask : chk_b

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic check_pkt(input logic [15:0] mask, input int bad);
        logic [37:0] b;
        int          n;
        n = 0;
        for (int c = 0; c < 16; c++) begin
            if (mask[c]) begin
                b = (bq.size() > 0) ? bq.pop_front() : 38'h0;
                chk_w({28'h0, b[35:32]}, 32'(c));
                chk_w(b[31:0], (c == bad) ? `SRP_TEMP_INVALID : val_of(4'(c)));
                chk_b(b[37], n == 0);
                chk_b(b[36], (mask >> (c + 1)) == 16'h0);
                n++;
            end
        end
        chk_w(32'(bq.size()), 32'h0);
    endtask : check_pkt

    // ============================================================
    // Scenarios
    task automatic vol_req(input logic [15:0] mask);
        bq.delete();
        usr_mask <= mask;
        usr_start <= 1'b1;
        @(posedge clk);
        usr_start <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 900 && usr_busy !== 1'b0; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        check_pkt(mask, -1);
        chk_b(miss_seen, 1'b0);
    endtask : vol_req

    // Reset while the first reading is awaited must clear both ends at once
    task automatic sc_reset();
        ack_dly <= 8'h05;
        usr_mask <= 16'h0003;
        usr_start <= 1'b1;
        @(posedge clk);
        usr_start <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        chk_b(usr_busy, 1'b0);
        chk_b(v_busy, 1'b0);
        chk_b(v_if.cmd_ready, 1'b1);
        chk_b(v_req, 1'b0);
        rst_n <= 1'b1;
        ack_dly <= 8'h00;
        repeat (2) @(posedge clk);
        vol_req(16'h0003);
    endtask : sc_reset

    task automatic sc_idle();
        bq.delete();
        usr_mask <= 16'h0003;
        usr_start <= 1'b1;
        @(posedge clk);
        user_mode <= 1'b1;
        usr_mask <= '0;
        @(posedge clk);
        usr_start <= 1'b0;
        @(posedge clk);
        chk_b(v_if.cmd_valid, 1'b0);
        chk_b(usr_busy, 1'b0);
    endtask : sc_idle

    task automatic sc_stall();
        ack_dly <= 8'h03;
        usr_stall <= 1'b1;
        fork
            vol_req(16'h8201);
            begin
                repeat (25) @(posedge clk);
                usr_stall <= 1'b0;
            end
        join
    endtask : sc_stall

    task automatic sc_temp();
        bq.delete();
        bad_ch <= 4'h7;
        t_if.cmd_data <= 9'h181;
        t_if.cmd_valid <= 1'b1;
        @(posedge clk);
        t_if.cmd_valid <= 1'b0;
        t_if.cmd_data <= '0;
        @(posedge clk);
        chk_b(t_if.cmd_ready, 1'b0);
        // Strobe while busy must leave no trace
        t_if.cmd_data <= 9'h002;
        t_if.cmd_valid <= 1'b1;
        repeat (3) @(posedge clk);
        t_if.cmd_valid <= 1'b0;
        t_if.cmd_data <= '0;
        for (int k = 0; k < 900 && t_busy !== 1'b0; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        check_pkt(16'h0181, 7);
        chk_b(t_if.cmd_ready, 1'b1);
    endtask : sc_temp

    initial begin
        t_if.cmd_valid = 1'b0;
        t_if.cmd_data = '0;
        t_if.rsp_ready = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        sc_idle();
        vol_req(16'h000b);
        sc_stall();
        ack_dly <= 8'h00;
        vol_req(16'hffff);
        vol_req(16'h0200);
        sc_reset();
        sc_temp();
        finish_test();
    end
endmodule : sensor_readout_stream_port_tb_top
